// File: eeprom_host_pkg.sv
// shared constants, types and byte builders for the two-wire eeprom host
package eeprom_host_pkg;

  // timing: scl runs at 400 khz, each bit split into four equal quarters
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int QTR_NS        = SCL_PERIOD_NS / 4;
  localparam int QTR_CYC       = (QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QCNT_W        = $clog2(QTR_CYC);
  localparam logic [QCNT_W-1:0] QCNT_LAST = QCNT_W'(QTR_CYC - 1);

  // memory organisation
  localparam int PAGE_COUNT = 128;
  localparam int PAGE_BYTES = 16;
  localparam int ADDR_W     = $clog2(PAGE_COUNT * PAGE_BYTES);

  // device address byte and word address byte layout
  localparam logic [3:0] ID_ARRAY      = 4'ha;
  localparam logic [3:0] ID_SERIAL     = 4'hb;
  localparam logic [2:0] SERIAL_HI     = 3'h0;
  localparam logic [1:0] SERIAL_WA_TOP = 2'h2;
  localparam int         ID_LSB        = 4;
  localparam int         HI_LSB        = 1;
  localparam int         RW_POS        = 0;
  localparam int         WA_TOP_LSB    = 6;

  // byte framing and recovery
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] REC_MAX  = 4'h9;

  typedef enum logic [1:0] {BOP_START, BOP_STOP, BOP_WRITE, BOP_READ} bitop_t;

  typedef enum logic [2:0] {
    CMD_ADDR, CMD_WORD, CMD_WRITE, CMD_READ, CMD_STOP, CMD_RECOVER
  } cmd_t;

  typedef enum {S_IDLE, S_WAIT_FREE, S_START, S_BITS, S_ACK, S_STOP, S_RECOV} state_t;

  function automatic logic [7:0] dev_addr_byte(input logic serial,
                                               input logic [2:0] hi,
                                               input logic rw);
    logic [7:0] b;
    b = 8'h00;
    b[ID_LSB +: 4] = serial ? ID_SERIAL : ID_ARRAY;
    b[HI_LSB +: 3] = serial ? SERIAL_HI : hi;
    b[RW_POS]      = rw;
    return b;
  endfunction

  function automatic logic [7:0] word_addr_byte(input logic serial, input logic [7:0] lo);
    logic [7:0] b;
    b = lo;
    if (serial) begin
      b[WA_TOP_LSB +: 2] = SERIAL_WA_TOP;
    end
    return b;
  endfunction

endpackage

// File: twi_bit_if.sv
// bit-level request and answer between the byte sequencer and the bit engine
interface twi_bit_if;
  import eeprom_host_pkg::*;
  logic   req;
  bitop_t op;
  logic   wbit;
  logic   done;
  logic   rbit;
  modport seq    (output req, output op, output wbit, input done, input rbit);
  modport engine (input req, input op, input wbit, output done, output rbit);
endinterface

// File: twi_bit_engine.sv
// bit engine: one start, stop, written bit or read bit per request, in four quarters
module twi_bit_engine (
  // clock and control
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // bus pin
  input  wire logic sda_pin,
  // sequencer side
  twi_bit_if.engine bif,
  // pin drivers and synced level
  output logic      scl_o,
  output logic      sda_rel,
  output logic      sda_level
);
  import eeprom_host_pkg::*;

  logic              sda_s1_r;
  logic              sda_s2_r;
  logic              busy_r;
  bitop_t            op_r;
  logic              wbit_r;
  logic [QCNT_W-1:0] qcnt_r;
  logic [1:0]        phase_r;
  logic              scl_r;
  logic              rel_r;
  logic              done_r;
  logic              rbit_r;
  logic              scl_nxt;
  logic              rel_nxt;

  wire logic       accept  = !busy_r && bif.req;
  wire logic       qtr_end = busy_r && (qcnt_r == QCNT_LAST);
  wire logic       last    = qtr_end && (phase_r == 2'h3);
  wire logic       step    = accept || (qtr_end && (phase_r != 2'h3));
  wire bitop_t     op_n    = accept ? bif.op : op_r;
  wire logic [1:0] ph_n    = accept ? 2'h0 : 2'(phase_r + 2'h1);
  wire logic       b_n     = accept ? bif.wbit : wbit_r;

  // pin actions taken on entering each quarter
  always_comb begin
    scl_nxt = scl_r;
    rel_nxt = rel_r;
    if (step) begin
      case (op_n)
        BOP_START: begin
          if (ph_n == 2'h0) rel_nxt = 1'b1;
          if (ph_n == 2'h1) scl_nxt = 1'b1;
          if (ph_n == 2'h2) rel_nxt = 1'b0;
          if (ph_n == 2'h3) scl_nxt = 1'b0;
        end
        BOP_STOP: begin
          if (ph_n == 2'h0) begin
            scl_nxt = 1'b0;
            rel_nxt = 1'b0;
          end
          if (ph_n == 2'h1) scl_nxt = 1'b1;
          if (ph_n == 2'h2) rel_nxt = 1'b1;
        end
        BOP_WRITE: begin
          if (ph_n == 2'h0) rel_nxt = b_n;
          if (ph_n == 2'h1) scl_nxt = 1'b1;
          if (ph_n == 2'h3) scl_nxt = 1'b0;
        end
        default: begin
          if (ph_n == 2'h0) rel_nxt = 1'b1;
          if (ph_n == 2'h1) scl_nxt = 1'b1;
          if (ph_n == 2'h3) scl_nxt = 1'b0;
        end
      endcase
    end
    // a driven bit is let go once scl is low again, so the far end may answer
    if (last && op_r == BOP_WRITE) rel_nxt = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      busy_r   <= 1'b0;
      op_r     <= BOP_READ;
      wbit_r   <= 1'b1;
      qcnt_r   <= '0;
      phase_r  <= 2'h0;
      scl_r    <= 1'b1;
      rel_r    <= 1'b1;
      done_r   <= 1'b0;
      rbit_r   <= 1'b1;
    end else if (ce) begin
      sda_s1_r <= sda_pin;
      sda_s2_r <= sda_s1_r;
      scl_r    <= scl_nxt;
      rel_r    <= rel_nxt;
      done_r   <= last;
      if (accept) begin
        busy_r  <= 1'b1;
        op_r    <= bif.op;
        wbit_r  <= bif.wbit;
        qcnt_r  <= '0;
        phase_r <= 2'h0;
      end else if (busy_r) begin
        qcnt_r <= qtr_end ? '0 : QCNT_W'(qcnt_r + 1'b1);
        if (qtr_end) phase_r <= 2'(phase_r + 2'h1);
        if (last) busy_r <= 1'b0;
      end
      // sample after scl has stood high two full quarters
      if (qtr_end && phase_r == 2'h2) rbit_r <= sda_s2_r;
    end
  end

  assign scl_o     = scl_r;
  assign sda_rel   = rel_r;
  assign sda_level = sda_s2_r;
  assign bif.done  = done_r;
  assign bif.rbit  = rbit_r;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  AST_DATA_ONLY_SCL_LOW: assert property (
    ($changed(rel_r) && (op_r == BOP_WRITE || op_r == BOP_READ)) |-> !scl_r)
    else $error("data line moved while clock high");
  AST_START_SHAPE: assert property (
    ($fell(rel_r) && scl_r && $past(scl_r)) |-> (op_r == BOP_START && phase_r == 2'h2))
    else $error("falling data with clock high outside a start");
  AST_STOP_SHAPE: assert property (
    ($rose(rel_r) && scl_r && $past(scl_r)) |-> (op_r == BOP_STOP && phase_r == 2'h2))
    else $error("rising data with clock high outside a stop");
  AST_READ_RELEASED: assert property (
    (busy_r && op_r == BOP_READ && phase_r != 2'h0) |-> rel_r)
    else $error("data line held during a read slot");
  AST_RELEASE_AFTER_WRITE: assert property (
    (last && op_r == BOP_WRITE && ce) |=> (rel_r && !scl_r))
    else $error("data line not released after a written bit");
endmodule

// File: eeprom_host.sv
// two-wire host controller that addresses, writes and reads a serial eeprom
module eeprom_host (
  // clock, reset and freeze
  input  wire logic                       CLK_SYS,
  input  wire logic                       RST,
  input  wire logic                       CE,
  // command port
  input  wire logic                       CMD_VALID,
  output logic                            CMD_READY,
  input  wire eeprom_host_pkg::cmd_t      CMD_OP,
  input  wire logic                       CMD_SERIAL,
  input  wire logic                       CMD_RW,
  input  wire logic [eeprom_host_pkg::ADDR_W-1:0] CMD_ADDR,
  input  wire logic [7:0]                 CMD_DATA,
  input  wire logic                       CMD_LAST,
  // answer port
  output logic                            RSP_VALID,
  output logic [7:0]                      RSP_DATA,
  output logic                            RSP_ACK,
  output logic                            BUS_ACTIVE,
  // two-wire pins
  output logic                            SCL_O,
  input  wire logic                       SDA_I,
  output logic                            SDA_O,
  output logic                            SDA_OE_N
);
  import eeprom_host_pkg::*;

  twi_bit_if bif ();

  logic       scl_w;
  logic       rel_w;
  logic       sda_level;

  state_t     state_r,   state_nxt;
  logic       wait_r,    wait_nxt;
  logic       req_r,     req_nxt;
  bitop_t     op_r,      op_nxt;
  logic       wbit_r,    wbit_nxt;
  logic [7:0] shreg_r,   shreg_nxt;
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  logic [3:0] rec_cnt_r, rec_cnt_nxt;
  logic       reading_r, reading_nxt;
  logic       nack_r,    nack_nxt;
  logic       is_addr_r, is_addr_nxt;
  logic       rec_r,     rec_nxt;
  logic       xfer_r,    xfer_nxt;
  logic       ready_r,   ready_nxt;
  logic       rsp_v_r,   rsp_v_nxt;
  logic [7:0] rsp_d_r,   rsp_d_nxt;
  logic       rsp_a_r,   rsp_a_nxt;

  twi_bit_engine u_engine (
    .clk       (CLK_SYS),
    .rst       (RST),
    .ce        (CE),
    .sda_pin   (SDA_I),
    .bif       (bif),
    .scl_o     (scl_w),
    .sda_rel   (rel_w),
    .sda_level (sda_level)
  );

  assign bif.req  = req_r;
  assign bif.op   = op_r;
  assign bif.wbit = wbit_r;

  wire logic       accept   = ready_r && CMD_VALID;
  wire logic       bit_done = wait_r && bif.done;
  wire logic       bus_free = sda_level && scl_w;
  wire logic [7:0] dev_byte = dev_addr_byte(CMD_SERIAL, CMD_ADDR[ADDR_W-1:8], CMD_RW);
  wire logic [7:0] wa_byte  = word_addr_byte(CMD_SERIAL, CMD_ADDR[7:0]);
  wire logic [7:0] sh_in    = {shreg_r[6:0], bif.rbit};
  wire logic [3:0] bit_inc  = 4'(bit_cnt_r + 4'h1);
  wire logic [3:0] rec_inc  = 4'(rec_cnt_r + 4'h1);

  always_comb begin
    state_nxt   = state_r;
    wait_nxt    = wait_r;
    req_nxt     = 1'b0;
    op_nxt      = op_r;
    wbit_nxt    = wbit_r;
    shreg_nxt   = shreg_r;
    bit_cnt_nxt = bit_cnt_r;
    rec_cnt_nxt = rec_cnt_r;
    reading_nxt = reading_r;
    nack_nxt    = nack_r;
    is_addr_nxt = is_addr_r;
    rec_nxt     = rec_r;
    xfer_nxt    = xfer_r;
    ready_nxt   = ready_r;
    rsp_v_nxt   = 1'b0;
    rsp_d_nxt   = rsp_d_r;
    rsp_a_nxt   = rsp_a_r;
    case (state_r)
      S_IDLE: begin
        if (accept) begin
          ready_nxt   = 1'b0;
          bit_cnt_nxt = 4'h0;
          reading_nxt = 1'b0;
          is_addr_nxt = 1'b0;
          rec_nxt     = 1'b0;
          nack_nxt    = CMD_LAST;
          case (CMD_OP)
            eeprom_host_pkg::CMD_ADDR: begin
              shreg_nxt   = dev_byte;
              is_addr_nxt = 1'b1;
              // inside a transfer this becomes a repeated start
              state_nxt   = xfer_r ? S_START : S_WAIT_FREE;
            end
            CMD_WORD: begin
              shreg_nxt = wa_byte;
              state_nxt = S_BITS;
            end
            CMD_WRITE: begin
              shreg_nxt = CMD_DATA;
              state_nxt = S_BITS;
            end
            CMD_READ: begin
              reading_nxt = 1'b1;
              state_nxt   = S_BITS;
            end
            CMD_STOP: state_nxt = S_STOP;
            default: begin
              rec_cnt_nxt = 4'h0;
              state_nxt   = S_RECOV;
            end
          endcase
        end
      end
      S_WAIT_FREE: begin
        // a fresh start goes out only on an idle bus
        if (bus_free) state_nxt = S_START;
      end
      S_START: begin
        if (!wait_r) begin
          req_nxt  = 1'b1;
          op_nxt   = BOP_START;
          wait_nxt = 1'b1;
        end else if (bit_done) begin
          wait_nxt  = 1'b0;
          xfer_nxt  = 1'b1;
          state_nxt = rec_r ? S_STOP : S_BITS;
        end
      end
      S_BITS: begin
        if (!wait_r) begin
          req_nxt  = 1'b1;
          op_nxt   = reading_r ? BOP_READ : BOP_WRITE;
          wbit_nxt = shreg_r[7];
          wait_nxt = 1'b1;
        end else if (bit_done) begin
          wait_nxt    = 1'b0;
          shreg_nxt   = sh_in;
          bit_cnt_nxt = bit_inc;
          if (bit_cnt_r == BIT_LAST) state_nxt = S_ACK;
        end
      end
      S_ACK: begin
        if (!wait_r) begin
          req_nxt  = 1'b1;
          op_nxt   = reading_r ? BOP_WRITE : BOP_READ;
          wbit_nxt = nack_r;
          wait_nxt = 1'b1;
        end else if (bit_done) begin
          wait_nxt  = 1'b0;
          rsp_v_nxt = 1'b1;
          rsp_d_nxt = shreg_r;
          // a nack on the address byte also covers a busy write cycle
          rsp_a_nxt = reading_r ? !nack_r : !bif.rbit;
          ready_nxt = 1'b1;
          state_nxt = S_IDLE;
        end
      end
      S_STOP: begin
        if (!wait_r) begin
          req_nxt  = 1'b1;
          op_nxt   = BOP_STOP;
          wait_nxt = 1'b1;
        end else if (bit_done) begin
          wait_nxt  = 1'b0;
          xfer_nxt  = 1'b0;
          rsp_v_nxt = 1'b1;
          rsp_a_nxt = 1'b1;
          ready_nxt = 1'b1;
          state_nxt = S_IDLE;
        end
      end
      S_RECOV: begin
        if (!wait_r) begin
          req_nxt  = 1'b1;
          op_nxt   = BOP_READ;
          wait_nxt = 1'b1;
        end else if (bit_done) begin
          wait_nxt    = 1'b0;
          rec_cnt_nxt = rec_inc;
          if (bif.rbit) begin
            rec_nxt   = 1'b1;
            state_nxt = S_START;
          end else if (rec_inc == REC_MAX) begin
            // still held low: only a power cycle of the device helps now
            xfer_nxt  = 1'b0;
            rsp_v_nxt = 1'b1;
            rsp_a_nxt = 1'b0;
            ready_nxt = 1'b1;
            state_nxt = S_IDLE;
          end
        end
      end
      default: begin
        state_nxt = S_IDLE;
        ready_nxt = 1'b1;
        wait_nxt  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state_r   <= S_IDLE;
      wait_r    <= 1'b0;
      req_r     <= 1'b0;
      op_r      <= BOP_READ;
      wbit_r    <= 1'b1;
      shreg_r   <= 8'h00;
      bit_cnt_r <= 4'h0;
      rec_cnt_r <= 4'h0;
      reading_r <= 1'b0;
      nack_r    <= 1'b0;
      is_addr_r <= 1'b0;
      rec_r     <= 1'b0;
      xfer_r    <= 1'b0;
      ready_r   <= 1'b1;
      rsp_v_r   <= 1'b0;
      rsp_d_r   <= 8'h00;
      rsp_a_r   <= 1'b0;
    end else if (CE) begin
      state_r   <= state_nxt;
      wait_r    <= wait_nxt;
      req_r     <= req_nxt;
      op_r      <= op_nxt;
      wbit_r    <= wbit_nxt;
      shreg_r   <= shreg_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      rec_cnt_r <= rec_cnt_nxt;
      reading_r <= reading_nxt;
      nack_r    <= nack_nxt;
      is_addr_r <= is_addr_nxt;
      rec_r     <= rec_nxt;
      xfer_r    <= xfer_nxt;
      ready_r   <= ready_nxt;
      rsp_v_r   <= rsp_v_nxt;
      rsp_d_r   <= rsp_d_nxt;
      rsp_a_r   <= rsp_a_nxt;
    end
  end

  assign CMD_READY  = ready_r;
  assign RSP_VALID  = rsp_v_r;
  assign RSP_DATA   = rsp_d_r;
  assign RSP_ACK    = rsp_a_r;
  assign BUS_ACTIVE = xfer_r;
  assign SCL_O      = scl_w;
  // open drain: low is driven, high is only ever released
  assign SDA_O      = rel_w;
  assign SDA_OE_N   = rel_w;

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  AST_ADDR_ID: assert property (
    (state_r == S_BITS && is_addr_r && bit_cnt_r == 4'h0)
      |-> (shreg_r[7:4] == ID_ARRAY || shreg_r[7:4] == ID_SERIAL))
    else $error("device address byte carries a wrong identifier");
  AST_SERIAL_HI_ZERO: assert property (
    (state_r == S_BITS && is_addr_r && bit_cnt_r == 4'h0 && shreg_r[7:4] == ID_SERIAL)
      |-> shreg_r[3:1] == SERIAL_HI)
    else $error("serial region address byte has nonzero middle bits");
  AST_ACK_FOLLOWS_BYTE: assert property (
    (state_r == S_BITS && bit_done && bit_cnt_r == BIT_LAST && CE) |=> state_r == S_ACK)
    else $error("no acknowledge slot after eight bits");
  AST_MSB_FIRST: assert property (
    (state_r == S_BITS && !wait_r && !reading_r && CE) |=> (bif.wbit == $past(shreg_r[7])))
    else $error("bit sent is not the top of the shift register");
  AST_RECOVER_BOUND: assert property (
    rec_cnt_r <= REC_MAX)
    else $error("more than nine recovery clocks");
  AST_START_ON_IDLE: assert property (
    (state_r == S_WAIT_FREE && CE) ##1 (state_r == S_START) |-> $past(bus_free))
    else $error("fresh start issued on a busy bus");
  AST_READ_ACK_VALUE: assert property (
    (state_r == S_ACK && reading_r && req_r) |-> (bif.op == BOP_WRITE && bif.wbit == nack_r))
    else $error("host acknowledge bit does not match request");
  AST_RSP_ONE_CYCLE: assert property (
    (rsp_v_r && CE) |=> (!rsp_v_r && (ready_r == !$past(CMD_VALID))))
    else $error("answer pulse longer than one cycle");
endmodule

// File: eeprom_dev_model.sv
// behavioural serial eeprom that answers the host on the two-wire bus
module eeprom_dev_model #(
  parameter int         BUSY_NS = 35000,
  parameter logic [7:0] SN_SEED = 8'h5c
) (
  // bus lines as seen on the wire
  input  wire logic scl,
  input  wire logic sda,
  // open-drain pull of the device
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0]  mem [0:2047];
  logic [7:0]  sn [0:15];
  logic [7:0]  sh;
  logic [7:0]  tx;
  logic [10:0] ptr;
  logic        act;
  logic        rd;
  logic        ser;
  logic        ok;
  logic        ackslot;
  logic        rdend;
  logic        wrote;
  logic        drv_low;
  int          bitn;
  int          nbyte;
  int          stuck;
  time         busy_until;

  // stuck stands for a device left mid-byte; it lets go one clock at a time
  assign sda_low = drv_low | (stuck > 0);

  initial begin
    for (int i = 0; i < 16; i++) sn[i] = SN_SEED ^ 8'(i);
    act = 1'h0;
    drv_low = 1'h0;
    ackslot = 1'h0;
    stuck = 0;
    bitn = 0;
    busy_until = 0;
  end

  always @(negedge sda) begin
    if (scl === 1'h1) begin
      act = 1'h1;
      bitn = 0;
      nbyte = 0;
      ackslot = 1'h0;
      rdend = 1'h0;
      wrote = 1'h0;
      drv_low = 1'h0;
    end
  end

  always @(posedge sda) begin
    if (scl === 1'h1) begin
      if (act && wrote) busy_until = $time + BUSY_NS;
      act = 1'h0;
      drv_low = 1'h0;
    end
  end

  always @(posedge scl) begin
    if (act && ackslot) begin
      if (rd && sda) rdend = 1'h1;
    end else if (act) begin
      sh = {sh[6:0], sda};
      bitn++;
    end
  end

  always @(negedge scl) begin
    if (stuck > 0) stuck--;
    if (act && !ackslot && bitn == 8) begin
      ackslot = 1'h1;
      drv_low = 1'h0;
      if (nbyte == 0) begin
        ok = (sh[7:4] == 4'ha || (sh[7:4] == 4'hb && sh[3:1] == 3'h0));
        ok = ok && ($time >= busy_until);
        drv_low = ok;
        act = ok;
        ser = sh[4];
        rd = sh[0];
        ptr[10:8] = sh[3:1];
      end else if (!rd) begin
        drv_low = !ser || sh[7:6] == 2'h2;
        if (nbyte == 1) begin
          ptr[7:0] = sh;
        end else begin
          mem[ptr] = sh;
          ptr[3:0] = ptr[3:0] + 4'h1;
          wrote = 1'h1;
        end
      end
      nbyte++;
    end else if (act && ackslot) begin
      ackslot = 1'h0;
      bitn = 0;
      drv_low = 1'h0;
      act = !rdend;
      if (rd && !rdend) begin
        tx = ser ? sn[ptr[3:0]] : mem[ptr];
        ptr = ptr + 11'h001;
        drv_low = !tx[7];
      end
    end else if (act && rd && bitn > 0) begin
      drv_low = !tx[7 - bitn];
    end
  end
endmodule

// File: testbench.sv
// self-checking bench: host controller against the behavioural eeprom
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import eeprom_host_pkg::*;

  typedef struct packed {logic a; logic [7:0] d; logic cd;} exp_t;
  localparam logic [7:0] SN_KEY = 8'h5c;
  // the port of the same name hides the command code
  localparam cmd_t       OP_DEV = eeprom_host_pkg::CMD_ADDR;

  logic              CLK_SYS;
  logic              RST;
  logic              CE;
  logic              CMD_VALID;
  logic              CMD_SERIAL;
  logic              CMD_RW;
  logic              CMD_LAST;
  cmd_t              CMD_OP;
  logic [ADDR_W-1:0] CMD_ADDR;
  logic [7:0]        CMD_DATA;
  logic              CMD_READY;
  logic              RSP_VALID;
  logic [7:0]        RSP_DATA;
  logic              RSP_ACK;
  logic              BUS_ACTIVE;
  logic              SCL_O;
  logic              SDA_O;
  logic              SDA_OE_N;
  logic              sda_low;
  logic              sda;
  logic [10:0]       wa;
  logic [7:0]        wd;
  exp_t              e;
  exp_t              exp_q[$];
  int                err_total;
  int                comparisons;
  int                seed;
  logic              pause;
  wire               scl_dev;
  wire               sda_dev;

  // pull-up wire: low when either party pulls
  assign sda = (SDA_OE_N === 1'h0 || sda_low === 1'h1) ? 1'h0 : 1'h1;
  // input filter of the far end: shorter pulses never reach it
  assign #20 scl_dev = SCL_O;
  assign #20 sda_dev = sda;

  eeprom_host eeprom_host_i (.CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .CMD_VALID(CMD_VALID),
    .CMD_READY(CMD_READY), .CMD_OP(CMD_OP), .CMD_SERIAL(CMD_SERIAL), .CMD_RW(CMD_RW),
    .CMD_ADDR(CMD_ADDR), .CMD_DATA(CMD_DATA), .CMD_LAST(CMD_LAST), .RSP_VALID(RSP_VALID),
    .RSP_DATA(RSP_DATA), .RSP_ACK(RSP_ACK), .BUS_ACTIVE(BUS_ACTIVE), .SCL_O(SCL_O),
    .SDA_I(sda), .SDA_O(SDA_O), .SDA_OE_N(SDA_OE_N));

  eeprom_dev_model #(.BUSY_NS(35000), .SN_SEED(SN_KEY)) eeprom_dev_model_i (
    .scl(scl_dev), .sda(sda_dev), .sda_low(sda_low));

  initial CLK_SYS = 1'h0;
  always #2.5 CLK_SYS = ~CLK_SYS;

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    comparisons++;
    if (seen !== want) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // f = {serial, read, last}; answer noted as the command is offered
  task automatic cmd(input cmd_t op, input logic [2:0] f, input logic [7:0] d,
                     input logic ea, input logic [7:0] ed);
    int n;
    @(negedge CLK_SYS);
    check(CMD_READY, 8'h01);
    {CMD_SERIAL, CMD_RW, CMD_LAST} = f;
    CMD_OP = op;
    CMD_ADDR = wa;
    CMD_DATA = d;
    CMD_VALID = 1'h1;
    exp_q.push_back('{ea, ed, op == CMD_READ});
    @(negedge CLK_SYS);
    CMD_VALID = 1'h0;
    check(CMD_READY, 8'h00);
    n = 0;
    while (RSP_VALID !== 1'h1 && n < 20000) begin
      @(negedge CLK_SYS);
      // random freezes; the answer cycle always runs so the pulse stays one cycle
      CE = !pause || RSP_VALID === 1'h1 || 2'($random(seed)) != 2'h0;
      n++;
    end
    if (n >= 20000) begin
      err_total++;
      $display("Error at %0t: no answer to command", $time);
    end
  endtask

  // sampled on the falling edge, where the registered answer has settled
  always @(negedge CLK_SYS) begin
    if (RSP_VALID === 1'h1) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("Error at %0t: answer with nothing expected", $time);
      end else begin
        e = exp_q.pop_front();
        check(RSP_ACK, e.a);
        if (e.cd) check(RSP_DATA, e.d);
      end
    end
  end

  initial begin
    #450000;
    err_total++;
    conclude();
  end

  initial begin
    seed = 54;
    err_total = 0;
    comparisons = 0;
    RST = 1'h1;
    CE = 1'h1;
    pause = 1'h0;
    CMD_VALID = 1'h0;
    CMD_OP = CMD_STOP;
    {CMD_SERIAL, CMD_RW, CMD_LAST} = 3'h0;
    CMD_ADDR = '0;
    CMD_DATA = 8'h00;
    wa = 11'h000;
    repeat (5) @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    RST = 1'h0;
    check({SCL_O, sda, BUS_ACTIVE, SDA_O, RSP_VALID, CMD_READY}, 8'h35);
    wa = 11'($random(seed));
    wd = 8'($random(seed));
    cmd(OP_DEV, 3'h0, 8'h00, 1'h1, 8'h00);
    cmd(CMD_WORD, 3'h0, 8'h00, 1'h1, 8'h00);
    pause = 1'h1;
    cmd(CMD_WRITE, 3'h0, wd, 1'h1, 8'h00);
    pause = 1'h0;
    cmd(CMD_STOP, 3'h0, 8'h00, 1'h1, 8'h00);
    check(eeprom_dev_model_i.mem[wa], wd);
    check({BUS_ACTIVE, SCL_O, sda}, 8'h03);
    $display("test array write done");
    // the write cycle is still running, so the first address is refused
    cmd(OP_DEV, 3'h0, 8'h00, 1'h0, 8'h00);
    cmd(CMD_STOP, 3'h0, 8'h00, 1'h1, 8'h00);
    cmd(OP_DEV, 3'h0, 8'h00, 1'h1, 8'h00);
    cmd(CMD_WORD, 3'h0, 8'h00, 1'h1, 8'h00);
    cmd(OP_DEV, 3'h2, 8'h00, 1'h1, 8'h00);
    pause = 1'h1;
    cmd(CMD_READ, 3'h1, 8'h00, 1'h0, wd);
    pause = 1'h0;
    cmd(CMD_STOP, 3'h0, 8'h00, 1'h1, 8'h00);
    $display("test polling and random read done");
    wa = {3'h0, 8'($random(seed))};
    cmd(OP_DEV, 3'h4, 8'h00, 1'h1, 8'h00);
    cmd(CMD_WORD, 3'h4, 8'h00, 1'h1, 8'h00);
    cmd(OP_DEV, 3'h6, 8'h00, 1'h1, 8'h00);
    cmd(CMD_READ, 3'h4, 8'h00, 1'h1, SN_KEY ^ {4'h0, wa[3:0]});
    cmd(CMD_READ, 3'h5, 8'h00, 1'h0, SN_KEY ^ {4'h0, wa[3:0] + 4'h1});
    cmd(CMD_STOP, 3'h0, 8'h00, 1'h1, 8'h00);
    $display("test serial read done");
    for (int k = 0; k < 2; k++) begin
      eeprom_dev_model_i.stuck = (k == 0) ? 3 : 12;
      cmd(CMD_RECOVER, 3'h0, 8'h00, 1'(k == 0), 8'h00);
    end
    eeprom_dev_model_i.stuck = 0;
    $display("test recovery done");
    repeat (4) @(negedge CLK_SYS);
    check(8'(exp_q.size()), 8'h00);
    conclude();
  end
endmodule
